// ### dv/contact_monitor_asserts.sv
// Port checker for the contact input run monitor
`timescale 1ns/100ps
module contact_monitor_asserts (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic contact_in1, // Contact one
	input wire logic contact_in2, // Contact two
	input wire logic operating, // Running
	input wire logic contact_io_remote, // Remote state
	input wire logic input1_switch_fault_alarm, // Alarm one
	input wire logic input2_switch_fault_alarm // Alarm two
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [2:0] age;
	// Cycles since a contact last moved; state may only change shortly after
	always_ff @(posedge sys_clk) begin
		if (rst || $changed(contact_in1) || $changed(contact_in2)) age <= 3'h0;
		else if (age != 3'h7) age <= age + 3'h1;
	end
	property p_pready; pready; endproperty
	a_pready: assert property (p_pready) else $error("pready low");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_run; $rose(operating) |-> age < 3'h4; endproperty
	a_run: assert property (p_run) else $error("run without contact change");
	property p_rmt; $changed(contact_io_remote) |-> age < 3'h4; endproperty
	a_rmt: assert property (p_rmt) else $error("remote without contact change");
	property p_al2; $rose(input2_switch_fault_alarm) |-> $past(operating); endproperty
	a_al2: assert property (p_al2) else $error("alarm two while stopped");
	property p_al1; $rose(input1_switch_fault_alarm) |-> $past(operating); endproperty
	a_al1: assert property (p_al1) else $error("alarm one while stopped");
	property p_blk; (input1_switch_fault_alarm || input2_switch_fault_alarm) && !operating |=> !operating; endproperty
	a_blk: assert property (p_blk) else $error("run with alarm latched");
	property p_stk; $fell(input2_switch_fault_alarm) |->
		$past(psel && penable && pwrite && paddr == contact_input_pkg::REG_IRQ_STATUS); endproperty
	a_stk: assert property (p_stk) else $error("alarm two dropped alone");
endmodule
bind contact_input_run_monitor contact_monitor_asserts u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
	.pready, .pslverr, .contact_in1, .contact_in2, .operating, .contact_io_remote,
	.input1_switch_fault_alarm, .input2_switch_fault_alarm);

// ### dv/contact_partner.sv
// Customer contact model: level contacts and held toggle pulses
`timescale 1ns/100ps
module contact_partner #(parameter int HOLD = 1200) (
	input wire logic sys_clk, // Clock
	input wire logic lvl1, // Resting level of contact one
	input wire logic lvl2, // Resting level of contact two
	input wire logic [1:0] pulse, // Pulse request per contact
	output logic contact_in1, // Contact one
	output logic contact_in2, // Contact two
	output logic busy // Pulse in progress
);
	int cnt = 0;
	logic [1:0] sel = 2'h0;
	// A pulse stays closed for the whole hold, else the toggle may be lost
	always_ff @(posedge sys_clk) begin
		if (cnt != 0) cnt <= cnt - 1;
		else if (pulse != 2'h0) begin
			cnt <= HOLD;
			sel <= pulse;
		end
	end
	assign busy = cnt != 0;
	assign contact_in1 = lvl1 ^ (sel[0] && busy);
	assign contact_in2 = lvl2 ^ (sel[1] && busy);
endmodule

// ### dv/tb.sv
// Self-checking bench for the contact input run monitor
`timescale 1ns/100ps
module tb;
	localparam int TK = 4;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, contact_in1, contact_in2, operating, contact_io_remote, irq, busy;
	logic input1_switch_fault_alarm, input2_switch_fault_alarm;
	logic lvl1 = 1'b0, lvl2 = 1'b0;
	logic [1:0] pulse = 2'h0;
	logic [64:0] e;
	logic [64:0] expq[$];
	int fail_count = 0, n_tests = 0, d, f;
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	contact_input_run_monitor #(.TICK_CYCLES(TK)) dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .contact_in1, .contact_in2, .operating, .contact_io_remote,
		.input2_switch_fault_alarm, .input1_switch_fault_alarm, .irq);
	contact_partner #(.HOLD(300 * TK)) u_far (.sys_clk, .lvl1, .lvl2, .pulse, .contact_in1, .contact_in2, .busy);
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One APB transfer; an extra edge keeps back-to-back calls from colliding
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input logic er = 1'b0);
		expq.push_back({er, m, x});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask
	task automatic st(input logic [31:0] x);
		rd(contact_input_pkg::REG_STATUS, 32'h3, x);
	endtask
	task automatic al(input logic [31:0] x);
		rd(contact_input_pkg::REG_IRQ_STATUS, 32'h2, x);
	endtask
	task automatic lv(input logic a, input logic b);
		lvl1 <= a;
		lvl2 <= b;
		wt(4);
	endtask
	task automatic pls(input logic [1:0] p);
		pulse <= p;
		@(posedge sys_clk);
		pulse <= 2'h0;
		wt(2);
		while (busy) @(posedge sys_clk);
		wt(4);
	endtask
	// Completed reads are matched against the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && expq.size() != 0) begin
			e = expq.pop_front();
			check("prdata", {pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
		end
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(8479));
		d = 3 + $urandom % 3;
		f = 3 + $urandom % 3;
		wt(8);
		rst <= 1'b0;
		wt(1);
		rd(contact_input_pkg::REG_INPUT_CFG, 32'hFFFF_FFFF, 32'h0000_0001);
		rd(contact_input_pkg::REG_READ_DELAY, 32'hFFFF_FFFF, 32'h0);
		rd(contact_input_pkg::REG_OFF_DETECT, 32'hFFFF_FFFF, 32'h0);
		rd(12'h020, 32'hFFFF_FFFF, 32'h0, 1'b1);
		lv(1'b1, 1'b0);
		st(32'h1);
		lv(1'b0, 1'b0);
		st(32'h0);
		// No function: contacts do nothing
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h0);
		lv(1'b1, 1'b0);
		st(32'h0);
		lv(1'b0, 1'b0);
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h2);
		pls(2'h1);
		st(32'h1);
		pls(2'h1);
		st(32'h0);
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h50);
		lv(1'b0, 1'b1);
		st(32'h2);
		lv(1'b0, 1'b0);
		st(32'h0);
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h60);
		pls(2'h2);
		st(32'h2);
		pls(2'h2);
		st(32'h0);
		// Normally-open switch two behind run level on one
		wr(contact_input_pkg::REG_READ_DELAY, d);
		wr(contact_input_pkg::REG_OFF_DETECT, f);
		wr(contact_input_pkg::REG_IRQ_MASK, 32'h2);
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h31);
		lv(1'b0, 1'b1);
		lv(1'b1, 1'b1);
		wt(d * TK + 8);
		for (int i = 0; i < 2; i++) begin
			lvl2 <= 1'b0;
			wt((f - 1) * TK - 1);
			lvl2 <= 1'b1;
			wt(2);
		end
		al(32'h0);
		lv(1'b0, 1'b0);
		lv(1'b1, 1'b0);
		al(32'h0);
		wt((d + f) * TK + 8);
		al(32'h2);
		st(32'h0);
		check("irq", {32'h0, irq}, 33'h1);
		check("alarm2", {32'h0, input2_switch_fault_alarm}, 33'h1);
		wr(contact_input_pkg::REG_IRQ_MASK, 32'h0);
		check("irq", {32'h0, irq}, 33'h0);
		wr(contact_input_pkg::REG_IRQ_STATUS, 32'hF);
		wr(contact_input_pkg::REG_IRQ_MASK, 32'h2);
		al(32'h0);
		check("irq", {32'h0, irq}, 33'h0);
		// Stop first, then open: stays quiet
		lv(1'b0, 1'b1);
		lv(1'b1, 1'b1);
		lv(1'b0, 1'b1);
		lv(1'b0, 1'b0);
		wt((d + f) * TK + 8);
		al(32'h0);
		// Normally-closed: a closed contact is the fault
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h41);
		lv(1'b1, 1'b0);
		wt((d + f) * TK + 8);
		al(32'h0);
		lv(1'b1, 1'b1);
		wt(f * TK + 8);
		al(32'h2);
		wr(contact_input_pkg::REG_IRQ_STATUS, 32'hF);
		// Switch one ignored in contact-io mode, watched in local mode
		wr(contact_input_pkg::REG_INPUT_CFG, 32'h13);
		wr(contact_input_pkg::REG_MODE_CFG, 32'h1);
		lv(1'b0, 1'b0);
		lv(1'b0, 1'b1);
		wt((d + f) * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h1);
		wr(contact_input_pkg::REG_MODE_CFG, 32'h0);
		wt(f * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h4);
		// Simple protocol two ignores switch one, fieldbus watches it
		wr(contact_input_pkg::REG_IRQ_STATUS, 32'hF);
		wr(contact_input_pkg::REG_MODE_CFG, 32'h7);
		lv(1'b0, 1'b0);
		lv(1'b0, 1'b1);
		wt((d + f) * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h1);
		wr(contact_input_pkg::REG_MODE_CFG, 32'h2);
		wt(f * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h4);
		// Continue action: alarm raised, operation goes on
		wr(contact_input_pkg::REG_IRQ_STATUS, 32'hF);
		wr(contact_input_pkg::REG_MODE_CFG, 32'h10);
		lv(1'b0, 1'b0);
		lv(1'b0, 1'b1);
		wt((d + f) * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h5);
		// Disable action: no alarm once cleared
		wr(contact_input_pkg::REG_MODE_CFG, 32'h20);
		wr(contact_input_pkg::REG_IRQ_STATUS, 32'hF);
		wt(f * TK + 8);
		rd(contact_input_pkg::REG_STATUS, 32'h5, 32'h1);
		// Software stop ends monitoring as well
		wr(contact_input_pkg::REG_CONTROL, 32'h1);
		rd(contact_input_pkg::REG_STATUS, 32'h21, 32'h0);
		wt(2);
		print_verdict();
	end
endmodule

// ### rtl/contact_input_pkg.sv
// Package with register map, field layouts and timing constants for the contact input run monitor
package contact_input_pkg;
	// Register byte offsets
	localparam logic [11:0] REG_INPUT_CFG = 12'h000;
	localparam logic [11:0] REG_READ_DELAY = 12'h004;
	localparam logic [11:0] REG_OFF_DETECT = 12'h008;
	localparam logic [11:0] REG_MODE_CFG = 12'h00C;
	localparam logic [11:0] REG_STATUS = 12'h010;
	localparam logic [11:0] REG_IRQ_STATUS = 12'h014;
	localparam logic [11:0] REG_IRQ_MASK = 12'h018;
	localparam logic [11:0] REG_CONTROL = 12'h01C;

	// Input function codes, 3 bits per input
	typedef enum logic [2:0] {
		FUNC_OFF = 3'h0,
		FUNC_RUN_LEVEL = 3'h1,
		FUNC_RUN_PULSE = 3'h2,
		FUNC_SW_NO = 3'h3,
		FUNC_SW_NC = 3'h4,
		FUNC_RMT_LEVEL = 3'h5,
		FUNC_RMT_PULSE = 3'h6
	} input_func_t;

	// Communication modes
	typedef enum logic [1:0] {
		MODE_LOCAL = 2'h0,
		MODE_CONTACT_IO = 2'h1,
		MODE_FIELDBUS = 2'h2,
		MODE_SIMPLE = 2'h3
	} comm_mode_t;

	// Alarm action codes
	typedef enum logic [1:0] {
		ACT_STOP = 2'h0,
		ACT_CONTINUE = 2'h1,
		ACT_DISABLE = 2'h2
	} alarm_action_t;

	// Field positions
	localparam int IN1_FUNC_LSB = 0;
	localparam int IN2_FUNC_LSB = 4;
	localparam int FUNC_W = 3;
	localparam int MODE_LSB = 0;
	localparam int PROTO_SEL_BIT = 2;
	localparam int ACT1_LSB = 4;
	localparam int ACT2_LSB = 6;
	localparam int CTRL_STOP_BIT = 0;
	localparam int IRQ_W = 4;
	localparam int IRQ_SW1 = 0;
	localparam int IRQ_SW2 = 1;
	localparam int IRQ_RUN = 2;
	localparam int IRQ_STOP = 3;

	// Reset values
	localparam logic [31:0] INPUT_CFG_RESET = 32'h0000_0001;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
	localparam logic [31:0] MODE_CFG_RESET = 32'h0000_0000;

	// Timer tick: timers count in milliseconds
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// Least pulse hold the far side must give, for reference
	localparam int PULSE_HOLD_MS = 300;
endpackage

// ### rtl/contact_input_run_monitor.sv
// Contact input run/stop, remote select and external switch monitor with APB registers
// Contract
// - Two inputs; input one level run/stop, input two unused by default.
// - Level run/stop: run while input asserted, stop when deasserted.
// - Pulse run/stop: each falling edge toggles running and stopped.
// - Level remote select: remote while asserted, local otherwise.
// - Pulse remote select: each falling edge toggles local and remote.
// - Switch monitoring starts only after read delay from operation start.
// - Read delay resets to zero seconds.
// - Switch counts open only after staying open for OFF-detection time.
// - OFF-detection time resets to zero seconds.
// - Switch two open while running raises its alarm; action configurable.
// - Run/stop deassert stops; later switch opening raises no alarm.
// - No switch monitoring while not operating.
// - Fault on either or both switches alarms and stops, per action.
// - Switch one monitored only in local, fieldbus, simple protocol one.
// - Each switch input normally-open or normally-closed polarity.
// - With no function configured both inputs are ignored.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module contact_input_run_monitor #(
	parameter int TIMER_W = 16,
	parameter int TICK_CYCLES = contact_input_pkg::TICK_CYCLES
) (
	input wire logic sys_clk, // System clock, 20 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic contact_in1, // Contact input one, high when closed
	input wire logic contact_in2, // Contact input two, high when closed
	output logic operating, // Device running
	output logic contact_io_remote, // Contact-I/O remote state
	output logic input2_switch_fault_alarm, // Input two switch alarm
	output logic input1_switch_fault_alarm, // Input one switch alarm
	output logic irq // Level interrupt
);
	logic [31:0] input_cfg;
	logic [TIMER_W-1:0] read_delay;
	logic [TIMER_W-1:0] off_detect;
	logic [31:0] mode_cfg;
	logic [contact_input_pkg::IRQ_W-1:0] irq_status;
	logic [contact_input_pkg::IRQ_W-1:0] irq_mask;
	logic [31:0] tick_cnt;
	logic tick;
	logic in1_q;
	logic in2_q;
	logic [TIMER_W-1:0] delay_cnt;
	logic monitor_on;
	logic [TIMER_W-1:0] off_cnt1;
	logic [TIMER_W-1:0] off_cnt2;
	logic open1;
	logic open2;
	logic sw1_fault;
	logic sw2_fault;
	logic stop_by_alarm;
	logic run_start;
	logic run_stop;
	logic next_operating;
	logic sw_stop_pulse;
	contact_input_pkg::input_func_t func1;
	contact_input_pkg::input_func_t func2;
	contact_input_pkg::comm_mode_t mode;
	contact_input_pkg::alarm_action_t act1;
	contact_input_pkg::alarm_action_t act2;
	logic proto_two;
	logic sw1_allowed;
	logic wr;
	logic rd_ok;
	logic setup_phase;
	logic access_phase;
	logic rise1;
	logic fall1;
	logic rise2;
	logic fall2;
	logic status_wr;
	logic [contact_input_pkg::IRQ_W-1:0] irq_clear;
	logic [contact_input_pkg::IRQ_W-1:0] irq_event;
	logic [contact_input_pkg::IRQ_W-1:0] next_irq_status;
	logic next_alarm1;
	logic next_alarm2;
	logic run_event;
	logic stop_event;
	logic [31:0] status_word;

	// Writable bits of the two configuration words; the others read back as zero
	localparam logic [31:0] INPUT_CFG_MASK = 32'h0000_0077;
	localparam logic [31:0] MODE_CFG_MASK = 32'h0000_00F7;
	// Widths of the mode and action fields
	localparam int MODE_W = 2;
	localparam int ACT_W = 2;
	// Status bits in use; the rest of the word reads zero
	localparam int STATUS_W = 6;

	// Switch reads open: NO contact open is low, NC contact open is high
	function automatic logic switch_open(input contact_input_pkg::input_func_t f, input logic pin);
		switch_open = (f == contact_input_pkg::FUNC_SW_NC) ? pin : ~pin;
	endfunction

	// Function is a run/stop kind
	function automatic logic is_run(input contact_input_pkg::input_func_t f);
		is_run = (f == contact_input_pkg::FUNC_RUN_LEVEL) || (f == contact_input_pkg::FUNC_RUN_PULSE);
	endfunction

	// Function is a switch kind
	function automatic logic is_sw(input contact_input_pkg::input_func_t f);
		is_sw = (f == contact_input_pkg::FUNC_SW_NO) || (f == contact_input_pkg::FUNC_SW_NC);
	endfunction

	// Configuration fields
	assign func1 = contact_input_pkg::input_func_t'(input_cfg[contact_input_pkg::IN1_FUNC_LSB +: contact_input_pkg::FUNC_W]);
	assign func2 = contact_input_pkg::input_func_t'(input_cfg[contact_input_pkg::IN2_FUNC_LSB +: contact_input_pkg::FUNC_W]);
	assign mode = contact_input_pkg::comm_mode_t'(mode_cfg[contact_input_pkg::MODE_LSB +: MODE_W]);
	assign proto_two = mode_cfg[contact_input_pkg::PROTO_SEL_BIT];
	assign act1 = contact_input_pkg::alarm_action_t'(mode_cfg[contact_input_pkg::ACT1_LSB +: ACT_W]);
	assign act2 = contact_input_pkg::alarm_action_t'(mode_cfg[contact_input_pkg::ACT2_LSB +: ACT_W]);
	// Switch one only outside contact-I/O mode and simple protocol two; switch two always
	always_comb begin
		unique case (mode)
			contact_input_pkg::MODE_LOCAL: sw1_allowed = 1'b1;
			contact_input_pkg::MODE_CONTACT_IO: sw1_allowed = 1'b0;
			contact_input_pkg::MODE_FIELDBUS: sw1_allowed = 1'b1;
			contact_input_pkg::MODE_SIMPLE: sw1_allowed = !proto_two;
		endcase
	end

	// APB: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign wr = access_phase && pwrite;
	always_comb begin
		unique case (paddr)
			contact_input_pkg::REG_INPUT_CFG, contact_input_pkg::REG_READ_DELAY,
			contact_input_pkg::REG_OFF_DETECT, contact_input_pkg::REG_MODE_CFG,
			contact_input_pkg::REG_STATUS, contact_input_pkg::REG_IRQ_STATUS,
			contact_input_pkg::REG_IRQ_MASK, contact_input_pkg::REG_CONTROL: rd_ok = 1'b1;
			default: rd_ok = 1'b0;
		endcase
	end
	assign pslverr = access_phase && !rd_ok;

	// Status word: running, remote, alarm one, open one, open two, monitor active
	assign status_word = {(32 - STATUS_W)'(0), monitor_on, open2, open1,
		input1_switch_fault_alarm, contact_io_remote, operating};

	// Read data is registered from the setup cycle so it is ready in the access phase
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			unique case (paddr)
				contact_input_pkg::REG_INPUT_CFG: prdata <= input_cfg;
				contact_input_pkg::REG_READ_DELAY: prdata <= 32'(read_delay);
				contact_input_pkg::REG_OFF_DETECT: prdata <= 32'(off_detect);
				contact_input_pkg::REG_MODE_CFG: prdata <= mode_cfg;
				contact_input_pkg::REG_STATUS: prdata <= status_word;
				contact_input_pkg::REG_IRQ_STATUS: prdata <= 32'(irq_status);
				contact_input_pkg::REG_IRQ_MASK: prdata <= 32'(irq_mask);
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			input_cfg <= contact_input_pkg::INPUT_CFG_RESET;
			read_delay <= TIMER_W'(contact_input_pkg::TIMER_RESET);
			off_detect <= TIMER_W'(contact_input_pkg::TIMER_RESET);
			mode_cfg <= contact_input_pkg::MODE_CFG_RESET;
			irq_mask <= '0;
		end else if (wr) begin
			unique case (paddr)
				contact_input_pkg::REG_INPUT_CFG: input_cfg <= pwdata & INPUT_CFG_MASK;
				contact_input_pkg::REG_READ_DELAY: read_delay <= pwdata[TIMER_W-1:0];
				contact_input_pkg::REG_OFF_DETECT: off_detect <= pwdata[TIMER_W-1:0];
				contact_input_pkg::REG_MODE_CFG: mode_cfg <= pwdata & MODE_CFG_MASK;
				contact_input_pkg::REG_IRQ_MASK: irq_mask <= pwdata[contact_input_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Millisecond tick shared by both timers
	always_ff @(posedge sys_clk) begin
		if (rst || tick) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end
	// Last count of the prescaler; a shortened tick only speeds up tests
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	assign tick = (tick_cnt == TICK_LAST);

	// Previous input levels for rising- and falling-edge detection
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			in1_q <= 1'b0;
			in2_q <= 1'b0;
		end else begin
			in1_q <= contact_in1;
			in2_q <= contact_in2;
		end
	end

	// Edges of the sampled contacts
	assign rise1 = contact_in1 & ~in1_q;
	assign fall1 = ~contact_in1 & in1_q;
	assign rise2 = contact_in2 & ~in2_q;
	assign fall2 = ~contact_in2 & in2_q;

	// Run requests from whichever input carries run/stop; the far side holds pulses 300 ms
	always_comb begin
		run_start = 1'b0;
		run_stop = 1'b0;
		if (func1 == contact_input_pkg::FUNC_RUN_LEVEL) begin
			run_start = run_start | rise1;
			run_stop = run_stop | fall1;
		end else if (func1 == contact_input_pkg::FUNC_RUN_PULSE && fall1) begin
			run_start = ~operating;
			run_stop = operating;
		end
		if (func2 == contact_input_pkg::FUNC_RUN_LEVEL) begin
			run_start = run_start | rise2;
			run_stop = run_stop | fall2;
		end else if (func2 == contact_input_pkg::FUNC_RUN_PULSE && fall2) begin
			run_start = run_start | ~operating;
			run_stop = run_stop | operating;
		end
	end

	// Alarm stop only for switches whose action is stop
	always_comb begin
		stop_by_alarm = 1'b0;
		if (sw1_fault && act1 == contact_input_pkg::ACT_STOP) begin
			stop_by_alarm = 1'b1;
		end
		if (sw2_fault && act2 == contact_input_pkg::ACT_STOP) begin
			stop_by_alarm = 1'b1;
		end
	end
	// Operating state; no run function stops at once so the stop event is still flagged
	always_comb begin
		next_operating = operating;
		if (!(is_run(func1) || is_run(func2))) begin
			next_operating = 1'b0;
		end else if (stop_by_alarm || run_stop || sw_stop_pulse) begin
			next_operating = 1'b0;
		end else if (run_start && !input2_switch_fault_alarm && !input1_switch_fault_alarm) begin
			next_operating = 1'b1;
		end
	end
	// Software stop via control register
	assign sw_stop_pulse = wr && (paddr == contact_input_pkg::REG_CONTROL) && pwdata[contact_input_pkg::CTRL_STOP_BIT];
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			operating <= 1'b0;
		end else begin
			operating <= next_operating;
		end
	end

	// Remote select, input two only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			contact_io_remote <= 1'b0;
		end else if (func2 == contact_input_pkg::FUNC_RMT_LEVEL) begin
			contact_io_remote <= contact_in2;
		end else if (func2 == contact_input_pkg::FUNC_RMT_PULSE) begin
			if (fall2) begin
				contact_io_remote <= ~contact_io_remote;
			end
		end else begin
			contact_io_remote <= 1'b0;
		end
	end

	// Read delay from operation start; restarts whenever operation stops
	always_ff @(posedge sys_clk) begin
		if (rst || !operating) begin
			delay_cnt <= '0;
			monitor_on <= 1'b0;
		end else if (delay_cnt >= read_delay) begin
			monitor_on <= 1'b1;
		end else if (tick) begin
			delay_cnt <= delay_cnt + TIMER_W'(1);
		end
	end

	// OFF detection per switch; a closed switch restarts the count
	always_ff @(posedge sys_clk) begin
		if (rst || !monitor_on || !is_sw(func1) || !switch_open(func1, contact_in1)) begin
			off_cnt1 <= '0;
			open1 <= 1'b0;
		end else if (off_cnt1 >= off_detect) begin
			open1 <= 1'b1;
		end else if (tick) begin
			off_cnt1 <= off_cnt1 + TIMER_W'(1);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst || !monitor_on || !is_sw(func2) || !switch_open(func2, contact_in2)) begin
			off_cnt2 <= '0;
			open2 <= 1'b0;
		end else if (off_cnt2 >= off_detect) begin
			open2 <= 1'b1;
		end else if (tick) begin
			off_cnt2 <= off_cnt2 + TIMER_W'(1);
		end
	end

	// Faults are only raised while operating, so a stop first means no alarm later
	always_comb begin
		sw1_fault = 1'b0;
		sw2_fault = 1'b0;
		if (operating && act1 != contact_input_pkg::ACT_DISABLE) begin
			sw1_fault = open1 && sw1_allowed;
		end
		if (operating && act2 != contact_input_pkg::ACT_DISABLE) begin
			sw2_fault = open2;
		end
	end

	// Write-one clear of the event register
	assign status_wr = wr && (paddr == contact_input_pkg::REG_IRQ_STATUS);
	assign irq_clear = status_wr ? pwdata[contact_input_pkg::IRQ_W-1:0] : '0;

	// Alarms latch until cleared; a fault in the clearing cycle keeps its alarm
	always_comb begin
		next_alarm1 = input1_switch_fault_alarm && !irq_clear[contact_input_pkg::IRQ_SW1];
		next_alarm2 = input2_switch_fault_alarm && !irq_clear[contact_input_pkg::IRQ_SW2];
		if (sw1_fault) begin
			next_alarm1 = 1'b1;
		end
		if (sw2_fault) begin
			next_alarm2 = 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			input1_switch_fault_alarm <= 1'b0;
			input2_switch_fault_alarm <= 1'b0;
		end else begin
			input1_switch_fault_alarm <= next_alarm1;
			input2_switch_fault_alarm <= next_alarm2;
		end
	end

	// Run and stop events are the edges of the operating state
	assign run_event = ~operating & next_operating;
	assign stop_event = operating & ~next_operating;
	always_comb begin
		irq_event = '0;
		irq_event[contact_input_pkg::IRQ_SW1] = sw1_fault;
		irq_event[contact_input_pkg::IRQ_SW2] = sw2_fault;
		irq_event[contact_input_pkg::IRQ_RUN] = run_event;
		irq_event[contact_input_pkg::IRQ_STOP] = stop_event;
	end

	// Sticky event bits; a new event wins over a write-one clear in the same cycle
	assign next_irq_status = (irq_status & ~irq_clear) | irq_event;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end
	assign irq = |(irq_status & irq_mask);
endmodule
